/* File: hdl/cts_pkg.sv */
// Package for capture trigger and store control: register map, modes, field layout.
// Assumes a 32-bit classic Wishbone slave and a 25 MHz system clock.
package cts_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CHANNELS = 16;
    localparam int ADDR_BITS = 14;
    localparam int DEPTH_SHALLOW = 1024;
    localparam int DEPTH_DEEP = 16384;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_PATTERN = 8'h04;
    localparam logic [7:0] REG_CARE = 8'h08;
    localparam logic [7:0] REG_TRIG_DELAY = 8'h0c;
    localparam logic [7:0] REG_STOP_DELAY = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_STORED = 8'h18;
    localparam logic [7:0] REG_TRIG_ADDR = 8'h1c;
    localparam logic [7:0] REG_READ_ADDR = 8'h20;
    localparam logic [7:0] REG_READ_DATA = 8'h24;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_DEEP_BIT = 2;
    localparam int CTL_RUN_BIT = 3;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int STS_ARMED_BIT = 0;
    localparam int STS_ACTIVE_BIT = 1;
    localparam int STS_DONE_BIT = 2;
    localparam int STS_TRIG_BIT = 3;

    // ------------------------------------------------------------
    // Reset values and fixed address constants
    // ------------------------------------------------------------
    localparam logic [ADDR_BITS-1:0] STOP_DELAY_RESET = 14'h03ff;
    localparam logic [ADDR_BITS-1:0] EVENT_TRIG_DELAY = 14'h0001;
    localparam logic [ADDR_BITS-1:0] ADDR_ZERO = 14'h0000;
    localparam logic [ADDR_BITS-1:0] ADDR_ONE = 14'h0001;

    typedef enum logic [1:0] {
        CTS_MODE_START_type_unused,
        CTS_MODE_STOP,
        CTS_MODE_EVENT,
        CTS_MODE_RSVD
    } cts_mode_type;

    localparam cts_mode_type CTS_MODE_START = CTS_MODE_START_type_unused;

    typedef enum logic [1:0] {
        CTS_IDLE,
        CTS_ARMED,
        CTS_ACTIVE,
        CTS_DONE
    } cts_state_type;

    // Settings passed to the link domain
    typedef struct packed {
        cts_mode_type mode;
        logic deep;
        logic [CHANNELS-1:0] pattern;
        logic [CHANNELS-1:0] care;
        logic [ADDR_BITS-1:0] trig_delay;
        logic [ADDR_BITS-1:0] stop_delay;
    } cts_cfg_type;

    // Results passed back to the bus domain
    typedef struct packed {
        cts_state_type state;
        logic triggered;
        logic [ADDR_BITS:0] stored;
        logic [ADDR_BITS-1:0] trig_addr;
    } cts_res_type;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } cts_wb_out_type;

endpackage

/* File: hdl/cts_top.sv */
// Trigger and storage control of a multi-channel clocked data analyzer.
// Assumes a classic Wishbone master on clk, and the analysed device's clock on link_clk.
// Summary of operation
// - Start mode, zero trigger delay: the matching word lands at address 00000.
// - Each channel pattern is 0, 1 or don't care; don't care always matches.
// - Start mode: mismatch keeps the block armed; a match triggers it.
// - Stop mode: storage halts with the matching word last, older words before it.
// - Stop mode: mismatch keeps it active capturing; a match triggers it.
// - Event start compare mode forces the trigger delay to 00001.
// - Delay one puts the matching word at the last address, 1023 or 16383.
// - Larger trigger delay moves the matching word to earlier addresses.
// - Stored word count equals the stop delay plus one.
// - Stop delay tops at 1023 or 16383, filling all 1024 or 16384 words.
`timescale 1ns/1ns
`default_nettype none

module cts_top
    import cts_pkg::*;
#(
    parameter int CH = cts_pkg::CHANNELS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic [CH-1:0] chan_data,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import cts_pkg::*;

    // ------------------------------------------------------------
    // Bus domain state
    // ------------------------------------------------------------
    typedef struct packed {
        cts_cfg_type cfg;
        logic run;
        logic [ADDR_BITS-1:0] read_addr;
        logic go_tgl;
        logic [2:0] done_sync;
        cts_res_type res;
        cts_wb_out_type wb;
    } cts_bus_type;

    cts_bus_type r, next_r;

    // ------------------------------------------------------------
    // Link domain state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] go_sync;
        logic done_tgl;
        cts_cfg_type cfg;
        cts_state_type state;
        logic triggered;
        logic [ADDR_BITS-1:0] wr_addr;
        logic [ADDR_BITS-1:0] count;
        logic [ADDR_BITS:0] stored;
        logic [ADDR_BITS-1:0] trig_addr;
    } cts_link_type;

    cts_link_type l, next_l;

    logic [CH-1:0] mem [0:DEPTH_DEEP-1];
    logic [CH-1:0] rd_word;
    logic [CH-1:0] samp_d;
    logic [CH-1:0] samp_q;
    logic [1:0] lrst_sync;
    logic [CH-1:0] hit;
    logic match;
    logic mem_we;
    logic [ADDR_BITS-1:0] depth_last;
    logic [31:0] rd_mux;
    logic wb_req;

    // ------------------------------------------------------------
    // Channel sampling and pattern compare
    // ------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        samp_d <= chan_data;
        samp_q <= samp_d;
        lrst_sync <= {lrst_sync[0], reset_n};
    end

    genvar gi;
    generate
        for (gi = 0; gi < CH; gi++) begin : g_cmp
            assign hit[gi] = ~l.cfg.care[gi] | (samp_q[gi] == l.cfg.pattern[gi]);
        end
    endgenerate

    assign match = &hit;
    assign depth_last = l.cfg.deep ? ADDR_BITS'(DEPTH_DEEP - 1) : ADDR_BITS'(DEPTH_SHALLOW - 1);

    // ------------------------------------------------------------
    // Link domain capture machine
    // ------------------------------------------------------------
    always_comb begin
        next_l = l;
        mem_we = 1'b0;
        next_l.go_sync = {l.go_sync[1:0], r.go_tgl};
        case (l.state)
            CTS_IDLE, CTS_DONE: begin
                if (l.go_sync[2] != l.go_sync[1]) begin
                    next_l.cfg = r.cfg;
                    next_l.triggered = 1'b0;
                    next_l.count = ADDR_ZERO;
                    next_l.stored = '0;
                    if (r.cfg.mode == CTS_MODE_STOP) begin
                        next_l.wr_addr = ADDR_ZERO;
                        next_l.state = CTS_ACTIVE;
                    end else begin
                        // Matching word will land at minus the trigger delay
                        next_l.wr_addr = ADDR_ZERO - r.cfg.trig_delay;
                        next_l.state = CTS_ARMED;
                    end
                end
            end
            CTS_ARMED: begin
                // Storage starts with the matching word
                if (match) begin
                    mem_we = 1'b1;
                    next_l.wr_addr = (l.wr_addr + ADDR_ONE) & depth_last;
                    next_l.triggered = 1'b1;
                    next_l.trig_addr = l.wr_addr & depth_last;
                    next_l.count = ADDR_ZERO;
                    next_l.stored = (ADDR_BITS+1)'(l.cfg.stop_delay) + 1'b1;
                    if (l.cfg.stop_delay == ADDR_ZERO) begin
                        next_l.state = CTS_DONE;
                        next_l.done_tgl = ~l.done_tgl;
                    end else begin
                        next_l.state = CTS_ACTIVE;
                    end
                end
            end
            CTS_ACTIVE: begin
                mem_we = 1'b1;
                next_l.wr_addr = (l.wr_addr + ADDR_ONE) & depth_last;
                if (!l.triggered) begin
                    if (match) begin
                        // Stop mode: matching word is the last one stored
                        next_l.triggered = 1'b1;
                        next_l.trig_addr = l.wr_addr;
                        next_l.stored = (ADDR_BITS+1)'(l.cfg.stop_delay) + 1'b1;
                        next_l.state = CTS_DONE;
                        next_l.done_tgl = ~l.done_tgl;
                    end
                end else begin
                    next_l.count = l.count + ADDR_ONE;
                    if (next_l.count == l.cfg.stop_delay) begin
                        next_l.state = CTS_DONE;
                        next_l.done_tgl = ~l.done_tgl;
                    end
                end
            end
            default: next_l.state = CTS_IDLE;
        endcase
        if (!lrst_sync[1]) begin
            next_l = '0;
            next_l.state = CTS_IDLE;
            next_l.cfg.stop_delay = STOP_DELAY_RESET;
        end
    end

    always_ff @(posedge link_clk) begin
        l <= next_l;
        if (mem_we) begin
            mem[l.wr_addr & depth_last] <= samp_q;
        end
    end

    // Memory read for software; only safe while capture is not running
    always_ff @(posedge clk) begin
        rd_word <= mem[r.read_addr];
    end

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            REG_CONTROL: begin
                rd_mux[CTL_MODE_LSB +: 2] = r.cfg.mode;
                rd_mux[CTL_DEEP_BIT] = r.cfg.deep;
                rd_mux[CTL_RUN_BIT] = r.run;
            end
            REG_PATTERN: rd_mux[CH-1:0] = r.cfg.pattern;
            REG_CARE: rd_mux[CH-1:0] = r.cfg.care;
            REG_TRIG_DELAY: rd_mux[ADDR_BITS-1:0] = r.cfg.trig_delay;
            REG_STOP_DELAY: rd_mux[ADDR_BITS-1:0] = r.cfg.stop_delay;
            REG_STATUS: begin
                rd_mux[STS_ARMED_BIT] = r.res.state == CTS_ARMED;
                rd_mux[STS_ACTIVE_BIT] = r.res.state == CTS_ACTIVE;
                rd_mux[STS_DONE_BIT] = r.res.state == CTS_DONE;
                rd_mux[STS_TRIG_BIT] = r.res.triggered;
            end
            REG_STORED: rd_mux[ADDR_BITS:0] = r.res.stored;
            REG_TRIG_ADDR: rd_mux[ADDR_BITS-1:0] = r.res.trig_addr;
            REG_READ_ADDR: rd_mux[ADDR_BITS-1:0] = r.read_addr;
            REG_READ_DATA: rd_mux[CH-1:0] = rd_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Bus domain: Wishbone slave and crossings
    // ------------------------------------------------------------
    assign wb_req = wb_cyc_i & wb_stb_i & ~r.wb.ack;

    always_comb begin
        next_r = r;
        next_r.wb.ack = wb_req;
        next_r.done_sync = {r.done_sync[1:0], l.done_tgl};
        // Results sampled only after done toggle is seen, so they are stable
        if (r.done_sync[2] != r.done_sync[1]) begin
            next_r.res = {l.state, l.triggered, l.stored, l.trig_addr};
            next_r.run = 1'b0;
        end
        if (wb_req) begin
            next_r.wb.dat = rd_mux;
        end
        if (wb_req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                REG_CONTROL: begin
                    next_r.cfg.mode = cts_mode_type'(wb_dat_i[CTL_MODE_LSB +: 2]);
                    next_r.cfg.deep = wb_dat_i[CTL_DEEP_BIT];
                    if (wb_dat_i[CTL_RUN_BIT] && !r.run) begin
                        next_r.run = 1'b1;
                        next_r.go_tgl = ~r.go_tgl;
                        if (cts_mode_type'(wb_dat_i[CTL_MODE_LSB +: 2]) == CTS_MODE_STOP) begin
                            next_r.res.state = CTS_ACTIVE;
                        end else begin
                            next_r.res.state = CTS_ARMED;
                        end
                        next_r.res.triggered = 1'b0;
                    end
                    if (cts_mode_type'(wb_dat_i[CTL_MODE_LSB +: 2]) == CTS_MODE_EVENT) begin
                        next_r.cfg.trig_delay = EVENT_TRIG_DELAY;
                    end
                end
                REG_PATTERN: next_r.cfg.pattern = wb_dat_i[CH-1:0];
                REG_CARE: next_r.cfg.care = wb_dat_i[CH-1:0];
                REG_TRIG_DELAY: begin
                    if (r.cfg.mode != CTS_MODE_EVENT) begin
                        next_r.cfg.trig_delay = wb_dat_i[ADDR_BITS-1:0];
                    end
                end
                REG_STOP_DELAY: begin
                    // Mask to the selected memory depth: shallow mode clears bits 13 to 10
                    next_r.cfg.stop_delay = wb_dat_i[ADDR_BITS-1:0];
                    if (!r.cfg.deep) begin
                        next_r.cfg.stop_delay[ADDR_BITS-1:$clog2(DEPTH_SHALLOW)] = '0;
                    end
                end
                REG_READ_ADDR: next_r.read_addr = wb_dat_i[ADDR_BITS-1:0];
                default: next_r.read_addr = r.read_addr;
            endcase
        end
        if (!reset_n) begin
            next_r = '0;
            next_r.cfg.mode = CTS_MODE_START;
            next_r.cfg.stop_delay = STOP_DELAY_RESET;
            next_r.res.state = CTS_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign wb_dat_o = r.wb.dat;
    assign wb_ack_o = r.wb.ack;

endmodule

`default_nettype wire

/* File: tb/cts_top_properties.sv */
// Checker of bus timing and readbacks of the capture controller.
// Assumes it is bound to cts_top and sees only its bus ports.
`timescale 1ns/1ns
`default_nettype none
module cts_top_properties
    import cts_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    // ----
    // Shadow of written settings
    // ----
    logic wr_ack;
    logic rd_ack;
    logic care_ok;
    logic deep;
    logic [1:0] mode;
    logic [15:0] care;
    logic [13:0] stop;
    assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_ack = wb_ack_o && !wb_we_i;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            care_ok <= 1'b0;
            deep <= 1'b0;
            mode <= 2'h0;
            care <= 16'h0000;
            stop <= STOP_DELAY_RESET;
        end else if (wr_ack) begin
            if (wb_adr_i == REG_CONTROL) begin
                mode <= wb_dat_i[1:0];
                deep <= wb_dat_i[CTL_DEEP_BIT];
            end
            if (wb_adr_i == REG_CARE) begin
                care_ok <= 1'b1;
                care <= wb_dat_i[15:0];
            end
            if (wb_adr_i == REG_STOP_DELAY) begin
                stop <= deep ? wb_dat_i[13:0] : {4'h0, wb_dat_i[9:0]};
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ----
    // Properties
    // ----
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_no_stray;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("ack without request");
    property p_dat_hold;
        !(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved between accesses");
    property p_unmapped;
        rd_ack && wb_adr_i == 8'h40 |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_care;
        rd_ack && wb_adr_i == REG_CARE && care_ok |-> wb_dat_o[15:0] == care;
    endproperty
    a_care: assert property (p_care) else $error("care mask readback wrong");
    property p_event;
        rd_ack && wb_adr_i == REG_TRIG_DELAY && mode == CTS_MODE_EVENT
            |-> wb_dat_o[13:0] == EVENT_TRIG_DELAY;
    endproperty
    a_event: assert property (p_event) else $error("event mode delay not one");
    property p_stored;
        rd_ack && wb_adr_i == REG_STORED |-> wb_dat_o[14:0] == {1'b0, stop} + 15'h1;
    endproperty
    a_stored: assert property (p_stored) else $error("stored count wrong");
    c_stored: cover property (rd_ack && wb_adr_i == REG_STORED);
    c_event: cover property (rd_ack && wb_adr_i == REG_TRIG_DELAY && mode == CTS_MODE_EVENT);
    c_unmapped: cover property (rd_ack && wb_adr_i == 8'h40);
endmodule
bind cts_top cts_top_properties cts_top_properties_inst (.clk, .reset_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

/* File: tb/cts_dut_model.sv */
// Model of the analysed device: makes the link clock and a counting word.
// Assumes the bench raises hold_word to freeze the word at start_word.
`timescale 1ns/1ns
`default_nettype none
module cts_dut_model
    import cts_pkg::*;
(
    input wire logic hold_word,
    input wire logic [CHANNELS-1:0] start_word,
    output logic link_clk,
    output logic [CHANNELS-1:0] chan_data
);
    // ----
    // Clock and data
    // ----
    initial begin
        link_clk = 1'b0;
        chan_data = '0;
        #3;
        forever #6 link_clk = ~link_clk;
    end
    always @(posedge link_clk) begin
        if (hold_word) begin
            chan_data <= start_word;
        end else begin
            chan_data <= chan_data + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/capture_trigger_store_control_bench.sv */
// Bench of the capture controller: bus tasks, scoreboard queue, scenarios.
// Assumes cts_top, its checker and the device model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module capture_trigger_store_control_bench;
    import cts_pkg::*;
    logic clk, reset_n, link_clk, hold_word, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, e, m, t;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [15:0] chan_data, start_word, p;
    int fails, checks, seed, i, d;
    cts_top cts_top_inst (.clk, .reset_n, .link_clk, .chan_data, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    cts_dut_model cts_dut_model_inst (.hold_word, .start_word, .link_clk, .chan_data);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ----
    // Tasks
    // ----
    task automatic final_report;
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
            input logic [31:0] xe, input logic [31:0] xm);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= wd;
        if (!w) exp_q.push_back(xe & xm);
        if (!w) msk_q.push_back(xm);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            fails++;
            final_report;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd, 32'h0, 32'h0);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] xe, input logic [31:0] xm);
        bus(1'b0, a, 32'h0, xe, xm);
    endtask
    task automatic mem(input logic [31:0] a, input logic [15:0] xe, input logic [15:0] xm);
        wr(REG_READ_ADDR, a);
        chk(REG_READ_DATA, {16'h0, xe}, {16'h0, xm});
    endtask
    task automatic go(input logic [3:0] ctl, input logic [31:0] se, input logic [31:0] sm);
        int n;
        start_word <= p - 16'd100;
        hold_word <= 1'b1;
        wr(REG_PATTERN, {16'h0, p});
        wr(REG_CONTROL, {28'h0, ctl | 4'h8});
        repeat (40) @(posedge clk);
        chk(REG_STATUS, se, sm);
        hold_word <= 1'b0;
        n = 0;
        do begin
            chk(REG_STATUS, 32'h0, 32'h0);
            n++;
        end while (rd[STS_DONE_BIT] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            fails++;
            final_report;
        end
        repeat (4) @(posedge clk);
    endtask
    // ----
    // Scoreboard
    // ----
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 32'h0) begin
                checks++;
                if ((wb_dat_o & m) !== e) begin
                    fails++;
                    $display("wrong value at %0t: got %h want %h", $time, wb_dat_o, e);
                end
            end
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        seed = 69227;
        fails = 0;
        checks = 0;
        reset_n = 1'b0;
        hold_word = 1'b1;
        start_word = 16'h0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        chk(REG_STOP_DELAY, 32'h3ff, 32'hffffffff);
        wr(8'h40, 32'hffffffff);
        chk(8'h40, 32'h0, 32'hffffffff);
        p = 16'($random(seed));
        wr(REG_CARE, 32'hffff);
        wr(REG_TRIG_DELAY, 32'h0);
        wr(REG_STOP_DELAY, 32'd15);
        go(4'h0, 32'h1, 32'h9);
        chk(REG_STORED, 32'd16, 32'hffffffff);
        chk(REG_STATUS, 32'h8, 32'h8);
        mem(32'h0, p, 16'hffff);
        mem(32'd15, p + 16'd15, 16'hffff);
        p = 16'($random(seed));
        go(4'h1, 32'h2, 32'ha);
        chk(REG_TRIG_ADDR, 32'h0, 32'h0);
        t = rd;
        mem(t, p, 16'hffff);
        mem((t - 32'h1) & 32'h3ff, p - 16'h1, 16'hffff);
        wr(REG_CARE, 32'h00ff);
        chk(REG_CARE, 32'h00ff, 32'hffffffff);
        wr(REG_STOP_DELAY, 32'd1023);
        for (i = 0; i < 3; i++) begin
            p = 16'($random(seed));
            d = 1 + i * 3 + ($random(seed) & 1);
            wr(REG_TRIG_DELAY, d);
            go(4'h0, 32'h0, 32'h0);
            mem(1024 - d, p, 16'h00ff);
        end
        wr(REG_CARE, 32'hffff);
        for (i = 0; i < 2; i++) begin
            p = 16'($random(seed));
            wr(REG_CONTROL, {29'h0, i[0], 2'h2});
            wr(REG_TRIG_DELAY, 32'h5);
            wr(REG_STOP_DELAY, i ? 16383 : 1023);
            chk(REG_TRIG_DELAY, 32'h1, 32'hffffffff);
            go({1'b0, i[0], 2'h2}, 32'h0, 32'h0);
            chk(REG_STORED, i ? 16384 : 1024, 32'hffffffff);
            mem(i ? 16383 : 1023, p, 16'hffff);
            mem(32'h0, p + 16'h1, 16'hffff);
        end
        final_report;
    end
endmodule
`default_nettype wire
